// ### hw/dpm_power_mode_ctrl.sv
// Power mode controller: picks the powered circuit groups of the receiver.
// Assumes a serial-bus engine on clk_sys delivering decoded register accesses,
// and asynchronous detect and sync levels from the analog front end.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Power bit 0 in register 12h forces absolute power-down; only serial bus lives.
// - Analog activity is the OR of status bits 7, 6, 5 of register 11h.
// - Digital activity is status bit 4 of register 11h.
// - No activity, no override: seek mode with detectors, slicer, band gap powered.
// - Digital only: digital interface, analog detect, slicer, outputs, band gap on.
// - Analog only: analog interface, digital clock detect, slicer, outputs on.
// - Both active without override: select bit 0 analog, 1 digital.
// - Override set: ignore activity, select bit picks analog or digital.
// - Dedicated vsync selected drives hold window and passes to vsync output.
// - Priority: power-down, then override, then automatic detection.
// - No interface detected, no override: both interfaces off, activity pin low.
module dpm_power_mode_ctrl
  import dpm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Decoded register accesses from the serial-bus engine.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Asynchronous detect levels from the front end.
  input wire logic hsync_detect,
  input wire logic vsync_detect,
  input wire logic green_sync_detect,
  input wire logic digital_clock_detect,
  // Sync sources.
  input wire logic vsync_pin,
  input wire logic vsync_separated,
  // Power enables of the circuit groups.
  output logic en_serial_bus,
  output logic en_digital_iface,
  output logic en_digital_clk_det,
  output logic en_analog_iface,
  output logic en_analog_act_det,
  output logic en_green_sync_slicer,
  output logic en_outputs,
  output logic en_bandgap,
  // Status and sync outputs.
  output logic activity_present_pin,
  output logic vertical_sync_output,
  output logic pll_hold_window,
  output logic [1:0] power_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decision, shared by the next-state logic.
  function automatic dpm_mode_t pick_mode(input logic up, input logic ovr,
                                          input logic sel, input logic act_a,
                                          input logic act_d);
    if (!up) begin
      pick_mode = DPM_MODE_ABS_PD;
    end else if (ovr) begin
      pick_mode = sel ? DPM_MODE_DIGITAL : DPM_MODE_ANALOG;
    end else if (act_a && act_d) begin
      pick_mode = sel ? DPM_MODE_DIGITAL : DPM_MODE_ANALOG;
    end else if (act_a) begin
      pick_mode = DPM_MODE_ANALOG;
    end else if (act_d) begin
      pick_mode = DPM_MODE_DIGITAL;
    end else begin
      pick_mode = DPM_MODE_SEEK;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronise the detect and sync levels.
  logic [SYNC_WIDTH-1:0] sync_lv;

  dpm_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in({vsync_separated, vsync_pin, hsync_detect, vsync_detect,
               green_sync_detect, digital_clock_detect}),
    .sync_out(sync_lv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers: power control and the writable low nibble of the status.
  logic [7:0] power_control;
  logic [3:0] status_rw;
  logic [7:0] next_power_control;
  logic [3:0] next_status_rw;
  logic [7:0] next_reg_rdata;
  logic [7:0] status_rd;
  logic act_analog;
  logic act_digital;

  // Status view and activity indications.
  always_comb begin
    status_rd = {sync_lv[SYN_HSYNC_DET], sync_lv[SYN_VSYNC_DET],
                 sync_lv[SYN_GREEN], sync_lv[SYN_DIG_CLK], status_rw};
    act_analog = status_rd[STAT_HSYNC_DET_BIT] | status_rd[STAT_VSYNC_DET_BIT] |
                 status_rd[STAT_GREEN_DET_BIT];
    act_digital = status_rd[STAT_DIG_CLK_DET_BIT];
  end

  // Next register contents and read data; unmapped reads return zero.
  always_comb begin
    next_power_control = power_control;
    next_status_rw = status_rw;
    next_reg_rdata = reg_rdata;
    if (reg_wr && reg_addr == ADDR_POWER_CONTROL) begin
      next_power_control = reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_ACTIVITY_DETECT_STATUS) begin
      next_status_rw = reg_wdata[STAT_RW_MSB:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_POWER_CONTROL: next_reg_rdata = power_control;
        ADDR_ACTIVITY_DETECT_STATUS: next_reg_rdata = status_rd;
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  // Register file storage.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      power_control <= RST_POWER_CONTROL;
      status_rw <= RST_STATUS_RW;
      reg_rdata <= 8'h00;
    end else begin
      power_control <= next_power_control;
      status_rw <= next_status_rw;
      reg_rdata <= next_reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode and registered enables.
  dpm_mode_t mode;
  dpm_mode_t next_mode;
  logic [7:0] en_vec;
  logic [7:0] next_en_vec;
  logic next_activity;

  // Decode the mode into the enable vector of the next cycle.
  always_comb begin
    next_mode = pick_mode(power_control[CTL_POWER_UP_BIT],
                          power_control[CTL_OVERRIDE_BIT],
                          power_control[CTL_SELECT_BIT], act_analog, act_digital);
    // Order: bus, dig iface, dig clk det, ana iface, ana det, slicer, outputs, bandgap.
    // The analog activity detector stays on in analog mode as part of that interface.
    case (next_mode)
      DPM_MODE_SEEK: next_en_vec = 8'hAD;
      DPM_MODE_DIGITAL: next_en_vec = 8'hCF;
      DPM_MODE_ANALOG: next_en_vec = 8'hBF;
      default: next_en_vec = 8'h80;
    endcase
    next_activity = (next_mode == DPM_MODE_ANALOG) || (next_mode == DPM_MODE_DIGITAL);
  end

  // Enables change only on a clock edge, free of decode glitches.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode <= DPM_MODE_ABS_PD;
      en_vec <= 8'h80;
      activity_present_pin <= 1'b0;
    end else begin
      mode <= next_mode;
      en_vec <= next_en_vec;
      activity_present_pin <= next_activity;
    end
  end

  // Fan the vector out to the enable pins.
  always_comb begin
    en_serial_bus = en_vec[7];
    en_digital_iface = en_vec[6];
    en_digital_clk_det = en_vec[5];
    en_analog_iface = en_vec[4];
    en_analog_act_det = en_vec[3];
    en_green_sync_slicer = en_vec[2];
    en_outputs = en_vec[1];
    en_bandgap = en_vec[0];
    power_mode = mode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vertical sync routing and hold window source.
  logic next_vertical_sync_output;

  // Dedicated pin or separated sync, chosen by the source bit.
  always_comb begin
    next_vertical_sync_output = power_control[CTL_VSYNC_SRC_BIT] ? sync_lv[SYN_VSYNC_PIN] :
                 sync_lv[SYN_VSYNC_SEP];
  end

  // The hold window follows the chosen vertical sync.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      vertical_sync_output <= 1'b0;
      pll_hold_window <= 1'b0;
    end else begin
      vertical_sync_output <= next_vertical_sync_output;
      pll_hold_window <= next_vertical_sync_output;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_abs_pd;
    !power_control[CTL_POWER_UP_BIT] |=> (en_vec == 8'h80) && !activity_present_pin;
  endproperty
  a_abs_pd: assert property (p_abs_pd) else $error("power-down not absolute");

  property p_analog_or;
    power_control[CTL_POWER_UP_BIT] && !power_control[CTL_OVERRIDE_BIT] &&
    !act_digital && (sync_lv[SYN_HSYNC_DET] || sync_lv[SYN_VSYNC_DET] ||
    sync_lv[SYN_GREEN]) |=> en_analog_iface && !en_digital_iface;
  endproperty
  a_analog_or: assert property (p_analog_or) else $error("analog OR not honoured");

  property p_digital_bit;
    power_control[CTL_POWER_UP_BIT] && !power_control[CTL_OVERRIDE_BIT] &&
    !act_analog && sync_lv[SYN_DIG_CLK] |=> en_digital_iface && en_outputs;
  endproperty
  a_digital_bit: assert property (p_digital_bit) else $error("digital detect ignored");

  property p_seek;
    power_control[CTL_POWER_UP_BIT] && !power_control[CTL_OVERRIDE_BIT] &&
    !act_analog && !act_digital |=> en_digital_clk_det && en_analog_act_det &&
    !en_outputs && !en_analog_iface && !en_digital_iface;
  endproperty
  a_seek: assert property (p_seek) else $error("seek mode wrong");

  property p_digital_on;
    power_mode == DPM_MODE_DIGITAL |-> en_green_sync_slicer && en_bandgap &&
    en_analog_act_det && !en_analog_iface && !en_digital_clk_det;
  endproperty
  a_digital_on: assert property (p_digital_on) else $error("digital set wrong");

  property p_analog_on;
    power_mode == DPM_MODE_ANALOG |-> en_digital_clk_det && en_outputs &&
    en_bandgap && !en_digital_iface;
  endproperty
  a_analog_on: assert property (p_analog_on) else $error("analog set wrong");

  property p_both;
    power_control[CTL_POWER_UP_BIT] && act_analog && act_digital |=>
    power_mode == ($past(power_control[CTL_SELECT_BIT]) ? DPM_MODE_DIGITAL : DPM_MODE_ANALOG);
  endproperty
  a_both: assert property (p_both) else $error("arbitration wrong");

  property p_override;
    power_control[CTL_POWER_UP_BIT] && power_control[CTL_OVERRIDE_BIT] |=>
    en_outputs && (en_digital_iface == $past(power_control[CTL_SELECT_BIT]));
  endproperty
  a_override: assert property (p_override) else $error("override ignored");

  property p_vsync;
    power_control[CTL_VSYNC_SRC_BIT] |=> vertical_sync_output == $past(sync_lv[SYN_VSYNC_PIN]) &&
    pll_hold_window == vertical_sync_output;
  endproperty
  a_vsync: assert property (p_vsync) else $error("vsync not passed");

  property p_none_low;
    power_mode == DPM_MODE_SEEK |-> !activity_present_pin;
  endproperty
  a_none_low: assert property (p_none_low) else $error("activity pin high");

  // With settled inputs the registered enables and mode must not move on the next edge.
  property p_registered;
    $past(nrst) && $stable(power_control) && $stable(sync_lv) |=>
    $stable(en_vec) && $stable(power_mode);
  endproperty
  a_registered: assert property (p_registered) else $error("enable not settled");

endmodule
`default_nettype wire

// ### hw/dpm_pkg.sv
// Package for the dual-interface power mode controller.
// Assumes the serial-bus engine presents decoded register accesses.
package dpm_pkg;

  // Register offsets on the two-wire serial bus.
  localparam logic [7:0] ADDR_ACTIVITY_DETECT_STATUS = 8'h11;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h12;

  // Field positions in the activity detect status register.
  localparam int STAT_HSYNC_DET_BIT = 7;
  localparam int STAT_VSYNC_DET_BIT = 6;
  localparam int STAT_GREEN_DET_BIT = 5;
  localparam int STAT_DIG_CLK_DET_BIT = 4;
  localparam int STAT_RW_MSB = 3;

  // Field positions in the power control register.
  localparam int CTL_POWER_UP_BIT = 0;
  localparam int CTL_SELECT_BIT = 1;
  localparam int CTL_OVERRIDE_BIT = 2;
  localparam int CTL_VSYNC_SRC_BIT = 3;

  // Reset values.
  localparam logic [7:0] RST_POWER_CONTROL = 8'h01;
  localparam logic [3:0] RST_STATUS_RW = 4'h0;

  // Synchroniser layout of the incoming detect and sync levels.
  localparam int SYNC_WIDTH = 6;
  localparam int SYN_DIG_CLK = 0;
  localparam int SYN_GREEN = 1;
  localparam int SYN_VSYNC_DET = 2;
  localparam int SYN_HSYNC_DET = 3;
  localparam int SYN_VSYNC_PIN = 4;
  localparam int SYN_VSYNC_SEP = 5;

  // Power modes.
  typedef enum logic [1:0] {
    DPM_MODE_ABS_PD  = 2'b00,
    DPM_MODE_SEEK    = 2'b01,
    DPM_MODE_ANALOG  = 2'b10,
    DPM_MODE_DIGITAL = 2'b11
  } dpm_mode_t;

endpackage

// ### hw/dpm_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes each bit is a slow level; no bus coherence is implied.
`timescale 1ns/100ps
`default_nettype none
module dpm_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Levels.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // The first stage feeds only the second stage.
  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  // Register both stages.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule
`default_nettype wire

// ### testbench/dpm_host_model.sv
// Host model issuing decoded register accesses to the power mode controller.
// Assumes requests are launched on the falling edge of clk_sys.
`timescale 1ns/100ps
`default_nettype none
module dpm_host_model (
  // Clock.
  input wire logic clk_sys,
  // Decoded register accesses.
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // Idle bus at time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write strobe; the data lines then show the inverse so stale data never helps.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~data;
  endtask

  // One-cycle read strobe; data is taken a full cycle later.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_sys);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~addr;
    @(negedge clk_sys);
    data = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### testbench/dual_interface_power_mode_ctrl_tb_top.sv
// Self-checking bench for the power mode controller.
// Assumes the host model drives the register strobes; detects are driven here.
`timescale 1ns/100ps
`default_nettype none
module dual_interface_power_mode_ctrl_tb_top;
  import dpm_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, wd, sw;
  logic reg_wr, reg_rd;
  logic [3:0] det = 4'h0;
  logic [1:0] vs = 2'b00;
  logic e_bus, e_di, e_dc, e_ai, e_ad, e_sl, e_out, e_bg, act, vso, hold;
  logic [1:0] power_mode;
  dpm_mode_t m;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int unsigned seed_dummy;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timeout.
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Design and host.
  dpm_host_model dpm_host_model_inst (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  dpm_power_mode_ctrl dpm_power_mode_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hsync_detect(det[3]), .vsync_detect(det[2]),
    .green_sync_detect(det[1]), .digital_clock_detect(det[0]), .vsync_pin(vs[1]),
    .vsync_separated(vs[0]), .en_serial_bus(e_bus), .en_digital_iface(e_di),
    .en_digital_clk_det(e_dc), .en_analog_iface(e_ai), .en_analog_act_det(e_ad),
    .en_green_sync_slicer(e_sl), .en_outputs(e_out), .en_bandgap(e_bg),
    .activity_present_pin(act), .vertical_sync_output(vso), .pll_hold_window(hold),
    .power_mode(power_mode));

  ////////////////////////////////////////////////////////////////////////////
  // Expectations and reporting.
  function automatic dpm_mode_t exp_mode(input logic [2:0] c, input logic [3:0] d);
    if (!c[0]) return DPM_MODE_ABS_PD;
    if (c[2] || (|d[3:1] && d[0])) return c[1] ? DPM_MODE_DIGITAL : DPM_MODE_ANALOG;
    if (|d[3:1]) return DPM_MODE_ANALOG;
    return d[0] ? DPM_MODE_DIGITAL : DPM_MODE_SEEK;
  endfunction

  // Enable order: bus, dig iface, dig clk det, ana iface, ana det, slicer, outputs, band gap.
  function automatic logic [7:0] exp_en(input dpm_mode_t md);
    case (md)
      DPM_MODE_SEEK: return 8'hAD;
      DPM_MODE_DIGITAL: return 8'hCF;
      DPM_MODE_ANALOG: return 8'hBF;
      default: return 8'h80;
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset, then corner cases followed by random settings.
  initial begin
    seed_dummy = $urandom(2);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check(8'(power_mode), 8'(DPM_MODE_ABS_PD));
    check(8'(e_bus), 8'h01);
    nrst = 1'b1;
    dpm_host_model_inst.read_reg(ADDR_POWER_CONTROL, rd);
    check(rd, RST_POWER_CONTROL);
    dpm_host_model_inst.read_reg(8'h20, rd);
    check(rd, 8'h00);
    for (int i = 0; i < 64; i++) begin
      @(negedge clk_sys);
      wd = 8'($urandom);
      sw = 8'($urandom);
      vs = 2'($urandom);
      det = 4'($urandom);
      if (i < 32) begin
        det = i[3:0];
        wd[3:0] = {wd[3], 1'b0, i[4], 1'b1};
      end
      dpm_host_model_inst.write_reg(ADDR_POWER_CONTROL, wd);
      repeat (4) @(negedge clk_sys);
      m = exp_mode(wd[2:0], det);
      check(8'(power_mode), 8'(m));
      check({e_bus, e_di, e_dc, e_ai, e_ad, e_sl, e_out, e_bg}, exp_en(m));
      check(8'(act), 8'(m[1]));
      check(8'(vso), 8'(wd[3] ? vs[1] : vs[0]));
      check(8'(hold), 8'(wd[3] ? vs[1] : vs[0]));
      dpm_host_model_inst.write_reg(ADDR_ACTIVITY_DETECT_STATUS, sw);
      dpm_host_model_inst.write_reg(8'h30, 8'h00);
      dpm_host_model_inst.read_reg(ADDR_ACTIVITY_DETECT_STATUS, rd);
      check(rd, {det, sw[3:0]});
      dpm_host_model_inst.read_reg(ADDR_POWER_CONTROL, rd);
      check(rd, wd);
      check(8'(power_mode), 8'(m));
    end
    finish_test();
  end
endmodule
`default_nettype wire
